//--- core/tlb_top.sv
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module tlb_top
  import tlb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic xlat_req,
  input wire tlb_xreq_t xlat_in,
  output logic xlat_ready,
  output logic xlat_done,
  output tlb_xrsp_t xlat_out,
  output logic pt_req,
  output logic [31:0] pt_addr,
  output logic pt_first,
  output logic pt_user,
  input wire logic pt_ack,
  input wire logic [31:0] pt_rdata,
  input wire logic cache_inhibit_input,
  output logic cache_inhibit_output,
  input wire logic dc_fill,
  input wire logic dc_fill_way,
  output logic cache_block_select_output,
  input wire logic cache_invalidate_instruction_req,
  input wire logic [31:0] cache_invalidate_instruction_operand,
  output logic slv_valid,
  output tlb_slv_t slv_out
);

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_WALK1, ST_WALK2} tlb_state_t;
  tlb_state_t state;                          // translation sequencer
  logic [1:0] memory_management_control;                            // translation enables
  logic [31:0] first_page_table_base;                          // space 0 table base
  logic [31:0] second_page_table_base;                          // space 1 table base
  logic [TLB_IDX_W-1:0] fifo_ptr;             // next recipient entry
  logic [TLB_ENTRIES-1:0] ent_valid;          // per entry valid flag
  logic [TLB_VPN_W-1:0] tag_vpn [TLB_ENTRIES];  // tag page numbers
  logic [TLB_ENTRIES-1:0] tag_as;             // tag address spaces
  tlb_xreq_t req_q;                           // reference in progress
  logic [TLB_IDX_W-1:0] hit_idx_q;            // entry found by lookup
  logic [31:0] first_level_table_entry_q;                        // first level entry read
  logic cii_s1;                               // inhibit pin, stage 1
  logic cii_s2;                               // inhibit pin, stage 2
  logic ci_last;                              // inhibit of last page

  // ----------------------------------------------------------------
  // combinational terms
  // ----------------------------------------------------------------
  logic [TLB_ENTRIES-1:0] match_vec;   // lookup hits
  logic [TLB_ENTRIES-1:0] purge_vec;   // purge address hits
  logic any_hit;
  logic [TLB_IDX_W-1:0] hit_idx;
  logic xlat_en;
  logic accept;
  tlb_val_t val_rd;
  tlb_val_t load_val;
  logic load_en;
  logic inval_en;
  logic wr_mcr, wr_first_page_table_base, wr_second_page_table_base, wr_ivar;
  logic ivar_as;
  logic [1:0] walk_pl;
  logic walk_ok;

  // access permission for a level, space and direction
  function automatic logic prot_ok(input logic [1:0] pl, input logic as, input logic wr);
    prot_ok = as ? (pl[1] && (!wr || pl[0])) : (!wr || (pl != 2'h0));
  endfunction : prot_ok

  assign xlat_ready = (state == ST_IDLE);
  assign accept = xlat_req && xlat_ready;
  // enable chosen by the space of the reference
  assign xlat_en = xlat_in.as ? memory_management_control[TLB_MCR_TU_BIT] : memory_management_control[TLB_MCR_TS_BIT];
  assign pt_req = (state == ST_WALK1) || (state == ST_WALK2);

  // register decode
  assign wr_mcr = reg_wr && (reg_addr == TLB_REG_MCR);
  assign wr_first_page_table_base = reg_wr && (reg_addr == TLB_REG_FIRST_PAGE_TABLE_BASE);
  assign wr_second_page_table_base = reg_wr && (reg_addr == TLB_REG_SECOND_PAGE_TABLE_BASE);
  assign wr_ivar = reg_wr && ((reg_addr == TLB_REG_IVAR0) || (reg_addr == TLB_REG_IVAR1));
  assign ivar_as = (reg_addr == TLB_REG_IVAR1);

  // ----------------------------------------------------------------
  // associative compare, two comparators per entry (lookup and purge)
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < TLB_ENTRIES; gi++)
    begin : g_ent
      // all tags compared at once
      assign match_vec[gi] = ent_valid[gi] && (tag_as[gi] == xlat_in.as) &&
                             (tag_vpn[gi] == xlat_in.vaddr[31:12]);
      assign purge_vec[gi] = ent_valid[gi] && (tag_as[gi] == ivar_as) &&
                             (tag_vpn[gi] == reg_wdata[31:12]);

      // tag fill from the reference that caused the walk
      always_ff @(posedge sys_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          tag_vpn[gi] <= '0;
          tag_as[gi] <= 1'b0;
        end
        else if (load_en && (fifo_ptr == gi))
        begin
          tag_vpn[gi] <= req_q.vaddr[31:12];
          tag_as[gi] <= req_q.as;
        end
      end

      // valid flag: a load wins over any purge in the same cycle
      always_ff @(posedge sys_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          ent_valid[gi] <= 1'b0;
        end
        else if (load_en && (fifo_ptr == gi))
        begin
          ent_valid[gi] <= 1'b1;
        end
        else if (inval_en && (hit_idx_q == gi))
        begin
          ent_valid[gi] <= 1'b0;
        end
        else if (wr_ivar && purge_vec[gi])
        begin
          ent_valid[gi] <= 1'b0;
        end
        else if ((wr_first_page_table_base && !tag_as[gi]) || (wr_second_page_table_base && tag_as[gi]))
        begin
          ent_valid[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // hit encoder; at most one entry matches since loads follow misses
  always_comb
  begin
    any_hit = |match_vec;
    hit_idx = '0;
    for (int k = 0; k < TLB_ENTRIES; k++)
    begin
      if (match_vec[k])
      begin
        hit_idx = k[TLB_IDX_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // value store
  // ----------------------------------------------------------------
  // the value is most restrictive level with second level bits
  assign walk_pl = (first_level_table_entry_q[TLB_PTE_PL_LSB +: 2] < pt_rdata[TLB_PTE_PL_LSB +: 2]) ?
                   first_level_table_entry_q[TLB_PTE_PL_LSB +: 2] : pt_rdata[TLB_PTE_PL_LSB +: 2];
  assign load_val.page_frame_number = pt_rdata[31:12];
  assign load_val.ci = pt_rdata[TLB_PTE_CI_BIT];
  assign load_val.m = pt_rdata[TLB_PTE_M_BIT];
  assign load_val.pl = walk_pl;
  assign walk_ok = first_level_table_entry_q[TLB_PTE_V_BIT] && pt_rdata[TLB_PTE_V_BIT] &&
                   prot_ok(walk_pl, req_q.as, req_q.wr);
  assign load_en = (state == ST_WALK2) && pt_ack && walk_ok;
  assign inval_en = (state == ST_CHECK) && req_q.wr && !val_rd.m;

  tlb_val_ram u_val_ram (
    .sys_clk(sys_clk),
    .wr_en(load_en),
    .wr_idx(fifo_ptr),
    .wr_data(load_val),
    .rd_idx(hit_idx),
    .rd_data(val_rd)
  );

  // ----------------------------------------------------------------
  // replacement pointer
  // ----------------------------------------------------------------
  // advances only on a load; a first page table base write resets it, other purges leave it alone
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fifo_ptr <= TLB_FIFO_RESET;
    end
    else if (wr_first_page_table_base)
    begin
      fifo_ptr <= TLB_FIFO_RESET;
    end
    else if (load_en)
    begin
      fifo_ptr <= fifo_ptr + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // enables and table bases; the entries are not touched here
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      memory_management_control <= TLB_MCR_RESET;
      first_page_table_base <= TLB_PTB_RESET;
      second_page_table_base <= TLB_PTB_RESET;
    end
    else
    begin
      if (wr_mcr)
      begin
        memory_management_control <= reg_wdata[1:0];
      end
      if (wr_first_page_table_base)
      begin
        first_page_table_base <= reg_wdata;
      end
      if (wr_second_page_table_base)
      begin
        second_page_table_base <= reg_wdata;
      end
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        TLB_REG_MCR: reg_rdata <= {30'h0, memory_management_control};
        TLB_REG_FIRST_PAGE_TABLE_BASE: reg_rdata <= first_page_table_base;
        TLB_REG_SECOND_PAGE_TABLE_BASE: reg_rdata <= second_page_table_base;
        TLB_REG_STAT: reg_rdata <= {23'h0, !xlat_ready, 2'h0, fifo_ptr};
        default: reg_rdata <= 32'h0000_0000;  // purge registers read zero
      endcase
    end
    else
    begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // translation sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_IDLE;
      req_q <= '0;
      hit_idx_q <= '0;
      first_level_table_entry_q <= 32'h0000_0000;
      pt_addr <= 32'h0000_0000;
      pt_first <= 1'b0;
      pt_user <= 1'b0;
      xlat_done <= 1'b0;
      xlat_out <= '0;
    end
    else
    begin
      xlat_done <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (accept)
          begin
            req_q <= xlat_in;
            hit_idx_q <= hit_idx;
            if (!xlat_en)
            begin
              // bypass: physical equals virtual
              xlat_done <= 1'b1;
              xlat_out <= '{paddr: xlat_in.vaddr, ci: 1'b0, abort: 1'b0};
            end
            else if (any_hit)
            begin
              state <= ST_CHECK;
            end
            else
            begin
              // miss: first level access carries upper half and space
              state <= ST_WALK1;
              pt_first <= 1'b1;
              pt_user <= xlat_in.as;
              pt_addr <= {(xlat_in.as ? second_page_table_base[31:12] : first_page_table_base[31:12]),
                          xlat_in.vaddr[31:22], 2'h0};
            end
          end
        end
        ST_CHECK:
        begin
          if (req_q.wr && !val_rd.m)
          begin
            // unmodified page on a write: entry dropped, walk again
            state <= ST_WALK1;
            pt_first <= 1'b1;
            pt_user <= req_q.as;
            pt_addr <= {(req_q.as ? second_page_table_base[31:12] : first_page_table_base[31:12]),
                        req_q.vaddr[31:22], 2'h0};
          end
          else
          begin
            state <= ST_IDLE;
            xlat_done <= 1'b1;
            xlat_out.paddr <= {val_rd.page_frame_number, req_q.vaddr[11:0]};
            xlat_out.ci <= val_rd.ci;
            xlat_out.abort <= !prot_ok(val_rd.pl, req_q.as, req_q.wr);
          end
        end
        ST_WALK1:
        begin
          if (pt_ack)
          begin
            first_level_table_entry_q <= pt_rdata;
            if (!pt_rdata[TLB_PTE_V_BIT])
            begin
              // invalid first level: no second access
              state <= ST_IDLE;
              pt_first <= 1'b0;
              xlat_done <= 1'b1;
              xlat_out <= '{paddr: req_q.vaddr, ci: 1'b0, abort: 1'b1};
            end
            else
            begin
              // second level access carries lower half of page number
              state <= ST_WALK2;
              pt_first <= 1'b0;
              pt_addr <= {pt_rdata[31:12], req_q.vaddr[21:12], 2'h0};
            end
          end
        end
        ST_WALK2:
        begin
          if (pt_ack)
          begin
            state <= ST_IDLE;
            xlat_done <= 1'b1;
            xlat_out.paddr <= {pt_rdata[31:12], req_q.vaddr[11:0]};
            xlat_out.ci <= pt_rdata[TLB_PTE_CI_BIT];
            xlat_out.abort <= !walk_ok;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // cache tracking outputs
  // ----------------------------------------------------------------
  // inhibit pin comes from outside the clock domain
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cii_s1 <= 1'b0;
      cii_s2 <= 1'b0;
    end
    else
    begin
      cii_s1 <= cache_inhibit_input;
      cii_s2 <= cii_s1;
    end
  end

  // set on the bus counts only while this output is low
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ci_last <= 1'b0;
      cache_inhibit_output <= 1'b0;
    end
    else
    begin
      if (xlat_done)
      begin
        ci_last <= xlat_out.ci;
      end
      cache_inhibit_output <= ci_last || cii_s2;
    end
  end

  // block being updated during a cacheable data read
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cache_block_select_output <= 1'b0;
    end
    else if (dc_fill && !cache_inhibit_output)
    begin
      cache_block_select_output <= dc_fill_way;
    end
  end

  // ----------------------------------------------------------------
  // slave cycle echo
  // ----------------------------------------------------------------
  // register loads take the cycle; a coinciding invalidate is dropped
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      slv_valid <= 1'b0;
      slv_out <= '0;
    end
    else
    begin
      slv_valid <= reg_wr || cache_invalidate_instruction_req;
      if (reg_wr)
      begin
        slv_out <= '{op: TLB_OP_LOAD, sel: reg_addr, operand: reg_wdata};
      end
      else if (cache_invalidate_instruction_req)
      begin
        slv_out <= '{op: TLB_OP_CACHE_INVALIDATE_INSTRUCTION, sel: 8'h00, operand: cache_invalidate_instruction_operand};
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_hit_read;
    accept && xlat_en && any_hit && !xlat_in.wr;
  endsequence
  sequence s_check_done;
    (state == ST_CHECK) ##1 xlat_done;
  endsequence

  property p_bypass;
    @(posedge sys_clk) disable iff (!arst_n)
    accept && !xlat_en |=> xlat_done && (xlat_out.paddr == $past(xlat_in.vaddr));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass address changed");

  property p_read_hit;
    @(posedge sys_clk) disable iff (!arst_n)
    s_hit_read |=> s_check_done;
  endproperty
  a_read_hit: assert property (p_read_hit) else $error("read hit not done in 2");

  property p_load_valid;
    @(posedge sys_clk) disable iff (!arst_n)
    load_en |-> first_level_table_entry_q[TLB_PTE_V_BIT] && pt_rdata[TLB_PTE_V_BIT] ##1
      (xlat_done && !xlat_out.abort);
  endproperty
  a_load_valid: assert property (p_load_valid) else $error("bad load");

  property p_fifo_step;
    @(posedge sys_clk) disable iff (!arst_n)
    load_en && !wr_first_page_table_base |=> fifo_ptr == $past(fifo_ptr) + 6'h01;
  endproperty
  a_fifo_step: assert property (p_fifo_step) else $error("pointer not stepped");

  property p_first_page_table_base_ptr;
    @(posedge sys_clk) disable iff (!arst_n)
    wr_first_page_table_base |=> fifo_ptr == TLB_FIFO_RESET;
  endproperty
  a_first_page_table_base_ptr: assert property (p_first_page_table_base_ptr) else $error("pointer not reset");

  property p_write_clean;
    @(posedge sys_clk) disable iff (!arst_n)
    inval_en |=> (state == ST_WALK1) && !ent_valid[hit_idx_q] && pt_first;
  endproperty
  a_write_clean: assert property (p_write_clean) else $error("entry kept");

  property p_first_addr;
    @(posedge sys_clk) disable iff (!arst_n)
    pt_req && pt_first |-> (pt_addr[11:2] == req_q.vaddr[31:22]) && (pt_user == req_q.as);
  endproperty
  a_first_addr: assert property (p_first_addr) else $error("first access address");

  property p_slave_echo;
    @(posedge sys_clk) disable iff (!arst_n)
    reg_wr |=> slv_valid && (slv_out.operand == $past(reg_wdata));
  endproperty
  a_slave_echo: assert property (p_slave_echo) else $error("load not echoed");

  property p_mcr_keep;
    @(posedge sys_clk) disable iff (!arst_n)
    wr_mcr && !load_en && !inval_en |=> ent_valid == $past(ent_valid);
  endproperty
  a_mcr_keep: assert property (p_mcr_keep) else $error("enable write hit entries");

  property p_ptb_purge;
    @(posedge sys_clk) disable iff (!arst_n)
    wr_second_page_table_base && !load_en |=> (ent_valid & tag_as) == '0;
  endproperty
  a_ptb_purge: assert property (p_ptb_purge) else $error("space not purged");

endmodule : tlb_top

//--- core/tlb_pkg.sv
package tlb_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int TLB_ENTRIES = 64;
  localparam int TLB_IDX_W = 6;
  localparam int TLB_VPN_W = 20;
  localparam int TLB_PFN_W = 20;
  localparam int TLB_VPN_HALF = 10;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] TLB_REG_MCR = 8'h00;    // translation enables
  localparam logic [7:0] TLB_REG_FIRST_PAGE_TABLE_BASE = 8'h04;   // first page table base
  localparam logic [7:0] TLB_REG_SECOND_PAGE_TABLE_BASE = 8'h08;   // second page table base
  localparam logic [7:0] TLB_REG_IVAR0 = 8'h0C;  // purge address, space 0
  localparam logic [7:0] TLB_REG_IVAR1 = 8'h10;  // purge address, space 1
  localparam logic [7:0] TLB_REG_STAT = 8'h14;   // replacement pointer, busy

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TLB_MCR_TU_BIT = 0;  // user translation enable
  localparam int TLB_MCR_TS_BIT = 1;  // supervisor translation enable
  localparam int TLB_PTE_V_BIT = 0;   // table entry valid
  localparam int TLB_PTE_PL_LSB = 1;  // protection level, 2 bits
  localparam int TLB_PTE_CI_BIT = 3;  // cache inhibit
  localparam int TLB_PTE_M_BIT = 4;   // modified
  localparam int TLB_STAT_BUSY_BIT = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] TLB_MCR_RESET = 2'h0;
  localparam logic [31:0] TLB_PTB_RESET = 32'h0000_0000;
  localparam logic [5:0] TLB_FIFO_RESET = 6'h00;

  // ----------------------------------------------------------------
  // slave cycle operation codes (arbitrary values)
  // ----------------------------------------------------------------
  localparam logic [7:0] TLB_OP_LOAD = 8'h0B;
  localparam logic [7:0] TLB_OP_CACHE_INVALIDATE_INSTRUCTION = 8'h27;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] vaddr;  // virtual address
    logic wr;            // write reference
    logic as;            // address space qualifier, 1 = user
  } tlb_xreq_t;

  typedef struct packed {
    logic [31:0] paddr;  // physical address
    logic ci;            // cache inhibit of the page
    logic abort;         // translation exception
  } tlb_xrsp_t;

  typedef struct packed {
    logic [TLB_PFN_W-1:0] page_frame_number;  // page frame number
    logic ci;                   // cache inhibit bit
    logic m;                    // modified bit
    logic [1:0] pl;             // protection level
  } tlb_val_t;

  typedef struct packed {
    logic [7:0] op;        // operation code
    logic [7:0] sel;       // register offset or cache select
    logic [31:0] operand;  // operand value
  } tlb_slv_t;

endpackage : tlb_pkg

//--- core/tlb_val_ram.sv
`timescale 1ns/1ps
// value store: one write port, one read port, registered read data
module tlb_val_ram
  import tlb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [TLB_IDX_W-1:0] wr_idx,
  input wire tlb_val_t wr_data,
  input wire logic [TLB_IDX_W-1:0] rd_idx,
  output tlb_val_t rd_data
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  tlb_val_t mem [TLB_ENTRIES];  // no reset: the tag valid flags guard it

  // write port
  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      mem[wr_idx] <= wr_data;
    end
  end

  // read port, one cycle of latency
  always_ff @(posedge sys_clk)
  begin
    rd_data <= mem[rd_idx];
  end

endmodule : tlb_val_ram

//--- tb/tlb_pt_model.sv
`timescale 1ns/1ps
// page table memory: answers each walk read after a chosen wait
module tlb_pt_model
  import tlb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic pt_req,
  input wire logic [31:0] pt_addr,
  input wire logic pt_first,
  input wire logic [1:0] pl,
  input wire logic m,
  input wire logic [1:0] dly,
  output logic pt_ack,
  output logic [31:0] pt_rdata
);
  logic [2:0] cnt; // cycles waited on this access
  initial
  begin
    pt_ack = 1'b0;
    pt_rdata = 32'h0;
    cnt = 3'h0;
  end
  // level one points at 0x00100000; level two frame follows the page
  always @(posedge sys_clk)
  begin
    if (pt_req && !pt_ack && cnt >= {1'b0, dly})
    begin
      pt_ack <= 1'b1;
      cnt <= 3'h0;
      pt_rdata <= pt_first ? 32'h0010_0007 : {10'h3C3, pt_addr[11:2], 7'h0, m, 1'b0, pl, 1'b1};
    end
    else
    begin
      // data is not left standing once the read is over
      pt_ack <= 1'b0;
      pt_rdata <= ~pt_rdata;
      cnt <= pt_req ? cnt + 3'h1 : 3'h0;
    end
  end
endmodule : tlb_pt_model

//--- tb/translation_lookaside_buffer_tb.sv
`timescale 1ns/1ps
module translation_lookaside_buffer_tb;
  import tlb_pkg::*;
  logic sys_clk, arst_n, reg_wr, reg_rd, xlat_req, xlat_ready, xlat_done;
  logic pt_req, pt_first, pt_ack, m;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, pt_addr, pt_rdata, seed, va, vw;
  logic [1:0] pl, dly;
  logic [5:0] ptr; // expected replacement pointer
  logic cii, dc_fill, dc_way, cache_invalidate_instruction_req, cbs, cio, slv_valid, pt_user;
  logic [31:0] cache_invalidate_instruction_op;
  logic [5:0] watch; // watcher's count of first level accesses
  tlb_slv_t slv_out;
  tlb_xreq_t xlat_in;
  tlb_xrsp_t xlat_out;
  int fail_count, n_checks;
  tlb_top dut (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .xlat_req, .xlat_in, .xlat_ready, .xlat_done, .xlat_out, .pt_req, .pt_addr,
    .pt_first, .pt_user, .pt_ack, .pt_rdata, .cache_inhibit_input(cii),
    .cache_inhibit_output(cio), .dc_fill, .dc_fill_way(dc_way),
    .cache_block_select_output(cbs), .cache_invalidate_instruction_req, .cache_invalidate_instruction_operand(cache_invalidate_instruction_op),
    .slv_valid, .slv_out);
  tlb_pt_model pt (.sys_clk, .pt_req, .pt_addr, .pt_first, .pl, .m, .dly, .pt_ack, .pt_rdata);
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // bus watcher: one count per first level access, all user space here
  always @(posedge sys_clk)
  begin
    if (!arst_n)
      watch <= 6'h00;
    else if (pt_ack && pt_first)
    begin
      watch <= watch + 6'h01;
      cmp({32'h0, pt_user}, 33'h1);
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // translated address that the table model implies
  function automatic logic [31:0] pa(input logic [31:0] a);
    return {10'h3C3, a[21:0]};
  endfunction : pa
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1 cmp({slv_valid, slv_out.operand}, {1'b1, d});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 cmp({1'b0, reg_rdata}, {1'b0, e});
  endtask : rd
  // user space reference; waits for done under a bound
  task automatic xl(input logic [31:0] a, input logic w, input logic [31:0] e, input logic ab);
    int n;
    @(posedge sys_clk);
    xlat_in <= tlb_xreq_t'{a, w, 1'b1};
    xlat_req <= 1'b1;
    dly <= a[13:12];
    @(posedge sys_clk);
    xlat_req <= 1'b0;
    #1 n = 0;
    while (xlat_done !== 1'b1 && n < 60)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n >= 60)
      fail_count++;
    cmp({ab ? 32'h0 : xlat_out.paddr, xlat_out.abort}, {e, ab});
  endtask : xl
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  initial
  begin
    #1000000 fail_count++;
    end_sim();
  end
  initial
  begin
    {reg_wr, reg_rd, xlat_req, arst_n, m} = '0;
    {reg_addr, reg_wdata, xlat_in, ptr} = '0;
    {cii, dc_fill, dc_way, cache_invalidate_instruction_req} = '0;
    cache_invalidate_instruction_op = 32'h0;
    pl = 2'h3;
    dly = 2'h0;
    seed = 32'hce209191;
    fail_count = 0;
    n_checks = 0;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(TLB_REG_STAT, 32'h0);
    rd(8'hFC, 32'h0);
    wr(TLB_REG_MCR, 32'h3);
    m <= 1'b1;
    repeat (8)
    begin
      va = rnd();
      xl(va, 1'b0, pa(va), 1'b0);
      xl(va, 1'b1, pa(va), 1'b0);
      ptr++;
      rd(TLB_REG_STAT, {26'h0, ptr});
    end
    m <= 1'b0;
    vw = rnd();
    xl(vw, 1'b0, pa(vw), 1'b0);
    xl(vw, 1'b1, pa(vw), 1'b0);
    ptr += 6'h2;
    rd(TLB_REG_STAT, {26'h0, ptr});
    wr(TLB_REG_IVAR0, vw);
    xl(vw, 1'b0, pa(vw), 1'b0);
    rd(TLB_REG_STAT, {26'h0, ptr});
    wr(TLB_REG_IVAR1, vw);
    xl(vw, 1'b0, pa(vw), 1'b0);
    ptr++;
    rd(TLB_REG_STAT, {26'h0, ptr});
    pl <= 2'h0;
    xl(rnd(), 1'b0, 32'h0, 1'b1);
    rd(TLB_REG_STAT, {26'h0, ptr});
    pl <= 2'h3;
    wr(TLB_REG_MCR, 32'h0);
    xl(vw, 1'b0, vw, 1'b0);
    wr(TLB_REG_MCR, 32'h3);
    xl(vw, 1'b0, pa(vw), 1'b0);
    rd(TLB_REG_STAT, {26'h0, ptr});
    wr(TLB_REG_FIRST_PAGE_TABLE_BASE, 32'h0);
    rd(TLB_REG_STAT, 32'h0);
    wr(TLB_REG_SECOND_PAGE_TABLE_BASE, 32'h0);
    xl(vw, 1'b0, pa(vw), 1'b0);
    rd(TLB_REG_STAT, 32'h1);
    @(posedge sys_clk);
    cii <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 cmp({32'h0, cio}, 33'h1);
    @(posedge sys_clk);
    dc_fill <= 1'b1;
    dc_way <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 cmp({32'h0, cbs}, 33'h0);
    @(posedge sys_clk);
    cii <= 1'b0;
    repeat (5) @(posedge sys_clk);
    #1 cmp({32'h0, cio}, 33'h0);
    cmp({32'h0, cbs}, 33'h1);
    @(posedge sys_clk);
    cache_invalidate_instruction_req <= 1'b1;
    cache_invalidate_instruction_op <= rnd();
    dc_fill <= 1'b0;
    @(posedge sys_clk);
    cache_invalidate_instruction_req <= 1'b0;
    #1 cmp({slv_valid, slv_out.operand}, {1'b1, cache_invalidate_instruction_op});
    cmp({25'h0, slv_out.op}, {25'h0, TLB_OP_CACHE_INVALIDATE_INSTRUCTION});
    cmp({27'h0, watch}, 33'h00D);
    end_sim();
  end
endmodule : translation_lookaside_buffer_tb
